// File: src/aldbc_dev.sv
/*
 * Device end: two-wire slave on the link clock, diagnostics, clip pin and shutdown on the system clock.
 * Assumes analog status inputs are asynchronous levels and the host keeps the two-wire framing.
 */
`timescale 1ns/1ns
module aldbc_dev #(
	parameter int P_HOLD_CYC = aldbc_pkg::HOLD_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_det_done,
	input wire logic [1:0] i_open,
	input wire logic [1:0] i_ocp,
	input wire logic i_uvp,
	input wire logic i_ovp,
	input wire logic i_hang,
	input wire logic i_offset,
	input wire logic i_otp,
	input wire logic i_tpw,
	input wire logic [1:0] i_clip,
	input wire logic i_ac_over,
	input wire logic [2:0] i_ads_code,
	input wire logic [2:0] i_mod_code,
	input wire logic i_out_switching,
	input wire logic i_en_pin,
	input wire logic i_muted,
	input wire logic i_soft_ramp_cap_pin_empty,
	input wire logic i_slave_mode,
	output logic o_det_enable,
	output logic o_det_start,
	output logic [1:0] o_ch_enable,
	output logic o_ac_det_enable,
	output logic o_clip_o,
	output logic o_clip_oe,
	output logic o_mute,
	output logic o_soft_ramp_cap_pin_discharge,
	output logic o_off,
	output logic o_osc_run,
	output logic o_bus_mode,
	output logic [7:0] o_wr_addr,
	aldbc_link_if.dev link
);
	localparam int NS = 29;
	localparam int HW = $clog2(P_HOLD_CYC + 1);

	// Link clock domain.
	logic start_tgl_ff, stop_mark_ff, start_seen_ff, ack_ff, wr_tgl_ff, rd_tgl_ff, sda_oe_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] sh_ff, rd_sh_ff, rx_byte;
	logic [1:0] byte_idx_ff;
	logic [7:0] ib_l_ff [aldbc_pkg::IB_COUNT];
	aldbc_pkg::aldbc_ph_t ph_ff;
	// System clock domain.
	logic [NS-1:0] s_q;
	logic det_done_s, uvp_s, ovp_s, hang_s, offset_s, otp_s, tpw_s, ac_over_s, sw_s, en_s, muted_s, empty_s, slave_s;
	logic start_s, stop_s, wr_s, rd_s;
	logic [1:0] open_s, ocp_s, clip_s;
	logic [2:0] ads_s, mod_s;
	logic [7:0] ib1_ff, ib2_ff, ib3_ff;
	logic [2:0] lat_ads_ff, lat_mod_ff;
	logic done_prev_ff, sw_prev_ff, det_prev_ff, wr_prev_ff, rd_prev_ff;
	logic [2:0] boot_ff;
	logic valid_ff, ovp_ff, uvp_ff, offset_ff, otp_ff, tpw_ff;
	logic [1:0] open_ff, short_ff;
	logic [15:0] snap_ff;
	logic [7:0] pub_addr_ff;
	logic pub_bus_ff;
	logic wr_ev, rd_ev, in_frame_s, bus_mode, ch_any, on_req, latch_now;
	logic [7:0] addr_calc;
	logic [HW-1:0] hold_cnt_ff;
	aldbc_pkg::aldbc_pwr_t pwr_ff;

	// Start and stop are SDA edges while SCL is high.
	always_ff @(negedge link.sda or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_tgl_ff <= 1'b0;
		end else if (link.scl) begin
			start_tgl_ff <= ~start_tgl_ff;
		end
	end

	always_ff @(posedge link.sda or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stop_mark_ff <= 1'b0;
		end else if (link.scl) begin
			stop_mark_ff <= start_tgl_ff;
		end
	end

	assign rx_byte = {sh_ff[6:0], link.sda};

	// Bits are taken on the rising SCL edge.
	always_ff @(posedge link.scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_seen_ff <= 1'b0;
			bit_cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			rd_sh_ff <= 8'hFF;
			ph_ff <= aldbc_pkg::PH_IGN;
			byte_idx_ff <= 2'h0;
			ack_ff <= 1'b0;
			wr_tgl_ff <= 1'b0;
			rd_tgl_ff <= 1'b0;
			for (int i = 0; i < aldbc_pkg::IB_COUNT; i++) begin
				ib_l_ff[i] <= aldbc_pkg::IB_RST;
			end
		end else if (start_tgl_ff != start_seen_ff) begin
			start_seen_ff <= start_tgl_ff;
			bit_cnt_ff <= 4'h1;
			sh_ff <= {7'h00, link.sda};
			ph_ff <= aldbc_pkg::PH_ADDR;
			byte_idx_ff <= 2'h0;
			ack_ff <= 1'b0;
		end else if (bit_cnt_ff == 4'h7) begin
			bit_cnt_ff <= 4'h8;
			sh_ff <= rx_byte;
			ack_ff <= 1'b0;
			case (ph_ff)
				aldbc_pkg::PH_ADDR: begin
					if (pub_bus_ff && rx_byte[7:1] == pub_addr_ff[7:1]) begin
						ack_ff <= 1'b1;
						if (rx_byte[0]) begin
							ph_ff <= aldbc_pkg::PH_RD;
							rd_tgl_ff <= ~rd_tgl_ff;
						end else begin
							ph_ff <= aldbc_pkg::PH_WR;
						end
					end else begin
						ph_ff <= aldbc_pkg::PH_IGN;
					end
				end
				aldbc_pkg::PH_WR: begin
					if (byte_idx_ff < 2'(aldbc_pkg::IB_COUNT)) begin
						ib_l_ff[byte_idx_ff] <= rx_byte;
						ack_ff <= 1'b1;
						byte_idx_ff <= byte_idx_ff + 2'h1;
						if (byte_idx_ff == 2'(aldbc_pkg::IB_COUNT - 1)) begin
							wr_tgl_ff <= ~wr_tgl_ff;
						end
					end
				end
				default: begin
				end
			endcase
		end else if (bit_cnt_ff == 4'h8) begin
			bit_cnt_ff <= 4'h0;
			if (ph_ff == aldbc_pkg::PH_RD) begin
				if (link.sda) begin
					ph_ff <= aldbc_pkg::PH_IGN;
				end else begin
					// The address acknowledge loads the first status byte, the first host acknowledge the second, later ones 8'h00.
					if (byte_idx_ff == 2'h0) begin
						rd_sh_ff <= snap_ff[15:8];
					end else if (byte_idx_ff == 2'h1) begin
						rd_sh_ff <= snap_ff[7:0];
					end else begin
						rd_sh_ff <= 8'h00;
					end
					if (!byte_idx_ff[1]) begin
						byte_idx_ff <= byte_idx_ff + 2'h1;
					end
				end
			end
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
			sh_ff <= rx_byte;
			if (ph_ff == aldbc_pkg::PH_RD) begin
				rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
			end
		end
	end

	// SDA is changed only after the falling SCL edge.
	always_ff @(negedge link.scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sda_oe_ff <= 1'b0;
		end else if (start_tgl_ff != start_seen_ff) begin
			sda_oe_ff <= 1'b0;
		end else if (bit_cnt_ff == 4'h8) begin
			sda_oe_ff <= ack_ff;
		end else begin
			sda_oe_ff <= (ph_ff == aldbc_pkg::PH_RD) && !rd_sh_ff[7];
		end
	end

	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = sda_oe_ff && (start_tgl_ff != stop_mark_ff);

	aldbc_sync #(.P_WIDTH(NS)) u_sync (
		.i_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_d({i_det_done, i_open, i_ocp, i_uvp, i_ovp, i_hang, i_offset, i_otp, i_tpw, i_clip, i_ac_over,
			i_ads_code, i_mod_code, i_out_switching, i_en_pin, i_muted, i_soft_ramp_cap_pin_empty, i_slave_mode,
			start_tgl_ff, stop_mark_ff, wr_tgl_ff, rd_tgl_ff}),
		.o_q(s_q)
	);
	assign {det_done_s, open_s, ocp_s, uvp_s, ovp_s, hang_s, offset_s, otp_s, tpw_s, clip_s, ac_over_s,
		ads_s, mod_s, sw_s, en_s, muted_s, empty_s, slave_s, start_s, stop_s, wr_s, rd_s} = s_q;

	assign wr_ev = wr_s ^ wr_prev_ff;
	assign rd_ev = rd_s ^ rd_prev_ff;
	assign in_frame_s = start_s ^ stop_s;
	assign bus_mode = lat_ads_ff != aldbc_pkg::ADS_SHORT;
	assign ch_any = ib1_ff[aldbc_pkg::IB_ON] && !(ib1_ff[aldbc_pkg::IB_CH_OFF] && ib2_ff[aldbc_pkg::IB_CH_OFF]);
	// Select pins are first latched once the synchroniser holds their real level.
	assign latch_now = (boot_ff == 3'h4) || (wr_ev && ib_l_ff[2][aldbc_pkg::IB_PIN_LATCH])
		|| (sw_s && !sw_prev_ff && (!bus_mode || !ib3_ff[aldbc_pkg::IB_PIN_LATCH]));
	assign addr_calc = {aldbc_pkg::ADDR_HI_BASE + 4'((lat_mod_ff >= aldbc_pkg::MOD_PARALLEL) ?
		lat_mod_ff - aldbc_pkg::MOD_PARALLEL : lat_mod_ff), 3'(lat_ads_ff - 3'h1), 1'b0};

	// Instruction bytes, event edges and select-pin latch.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ib1_ff <= aldbc_pkg::IB_RST;
			ib2_ff <= aldbc_pkg::IB_RST;
			ib3_ff <= aldbc_pkg::IB_RST;
			boot_ff <= 3'h7;
			lat_ads_ff <= aldbc_pkg::RES_CODE_RST;
			lat_mod_ff <= 3'h0;
			{done_prev_ff, sw_prev_ff, det_prev_ff, wr_prev_ff, rd_prev_ff} <= 5'h00;
		end else begin
			boot_ff <= {boot_ff[1:0], 1'b0};
			{done_prev_ff, sw_prev_ff, det_prev_ff, wr_prev_ff, rd_prev_ff} <=
				{det_done_s, sw_s, o_det_enable, wr_s, rd_s};
			if (wr_ev) begin
				ib1_ff <= ib_l_ff[0];
				ib2_ff <= ib_l_ff[1];
				ib3_ff <= ib_l_ff[2];
			end
			if (latch_now) begin
				lat_ads_ff <= ads_s;
				lat_mod_ff <= mod_s;
			end
		end
	end

	// Status latches; a new event wins over the clear that follows a read.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{valid_ff, ovp_ff, uvp_ff, offset_ff, otp_ff, tpw_ff} <= 6'h00;
			open_ff <= 2'h0;
			short_ff <= 2'h0;
		end else begin
			if (o_det_enable && (uvp_s || ovp_s || hang_s)) begin
				valid_ff <= 1'b0;
			end else if (det_done_s && !done_prev_ff && o_det_enable) begin
				valid_ff <= 1'b1;
				open_ff <= open_s;
			end
			short_ff <= (short_ff & {2{!rd_ev}}) | ocp_s;
			ovp_ff <= (ovp_ff && !rd_ev) || ovp_s;
			uvp_ff <= (uvp_ff && !rd_ev) || uvp_s;
			offset_ff <= (offset_ff && !rd_ev) || offset_s;
			otp_ff <= (otp_ff && !rd_ev) || otp_s;
			tpw_ff <= (tpw_ff && !rd_ev) || tpw_s;
		end
	end

	// Values seen by the link are only updated between frames.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			snap_ff <= aldbc_pkg::DB_RST;
			pub_addr_ff <= 8'h00;
			pub_bus_ff <= 1'b0;
		end else if (!in_frame_s) begin
			snap_ff <= {({ib1_ff, ib2_ff, ib3_ff} == 24'h000000), valid_ff, ovp_ff, open_ff[0], short_ff[0],
				offset_ff, 2'h0, otp_ff, tpw_ff, uvp_ff, open_ff[1], short_ff[1], 3'h0};
			pub_addr_ff <= addr_calc;
			pub_bus_ff <= bus_mode;
		end
	end

	// Detection control, enables and clip pin.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_det_enable <= 1'b0;
			o_det_start <= 1'b0;
			o_ch_enable <= 2'h0;
			o_ac_det_enable <= 1'b0;
			o_clip_oe <= 1'b0;
		end else begin
			o_det_enable <= bus_mode && ib2_ff[aldbc_pkg::IB_DET_EN];
			o_det_start <= o_det_enable && !det_prev_ff && !ch_any;
			o_ch_enable <= {!ib2_ff[aldbc_pkg::IB_CH_OFF], !ib1_ff[aldbc_pkg::IB_CH_OFF]} & {2{ch_any}};
			o_ac_det_enable <= bus_mode && ib3_ff[aldbc_pkg::IB_AC_EN];
			if (bus_mode) begin
				o_clip_oe <= (o_ac_det_enable && ac_over_s)
					|| (clip_s[0] && !ib1_ff[aldbc_pkg::IB_CLIP_OFF])
					|| (clip_s[1] && !ib2_ff[aldbc_pkg::IB_CLIP_OFF]);
			end else begin
				o_clip_oe <= |clip_s;
			end
		end
	end

	assign on_req = en_s && (!bus_mode || ib1_ff[aldbc_pkg::IB_ON]);

	// Power sequence: run, mute, discharge, clock hold unless in slave mode, off.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr_ff <= aldbc_pkg::PWR_OFF;
			hold_cnt_ff <= '0;
		end else begin
			case (pwr_ff)
				aldbc_pkg::PWR_OFF: begin
					if (on_req) begin
						pwr_ff <= aldbc_pkg::PWR_RUN;
					end
				end
				aldbc_pkg::PWR_RUN: begin
					if (!on_req) begin
						pwr_ff <= aldbc_pkg::PWR_MUTE;
					end
				end
				aldbc_pkg::PWR_MUTE: begin
					if (muted_s) begin
						pwr_ff <= aldbc_pkg::PWR_DISCH;
					end
				end
				aldbc_pkg::PWR_DISCH: begin
					if (empty_s) begin
						hold_cnt_ff <= HW'(P_HOLD_CYC - 1);
						pwr_ff <= slave_s ? aldbc_pkg::PWR_OFF : aldbc_pkg::PWR_HOLD;
					end
				end
				default: begin
					if (hold_cnt_ff == '0) begin
						pwr_ff <= aldbc_pkg::PWR_OFF;
					end else begin
						hold_cnt_ff <= hold_cnt_ff - HW'(1);
					end
				end
			endcase
		end
	end

	assign o_clip_o = 1'b0;
	assign o_mute = pwr_ff != aldbc_pkg::PWR_RUN;
	assign o_soft_ramp_cap_pin_discharge = pwr_ff == aldbc_pkg::PWR_DISCH;
	assign o_off = pwr_ff == aldbc_pkg::PWR_OFF;
	assign o_osc_run = pwr_ff != aldbc_pkg::PWR_OFF;
	assign o_bus_mode = pub_bus_ff;
	assign o_wr_addr = pub_addr_ff;
endmodule : aldbc_dev

// File: src/aldbc_host.sv
/*
 * Host end: two-wire master that writes three instruction bytes or reads two status bytes.
 * Assumes SCL is made here from the system clock; SDA is open drain.
 */
`timescale 1ns/1ns
module aldbc_host #(
	parameter int P_QTR = aldbc_pkg::SCL_QTR_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_rw,
	input wire logic [6:0] i_addr,
	input wire logic [23:0] i_wdata,
	output logic o_busy,
	output logic o_done,
	output logic o_nack,
	output logic [15:0] o_rdata,
	aldbc_link_if.host link
);
	localparam int QW = $clog2(P_QTR + 1);

	aldbc_pkg::aldbc_hst_t st_ff;
	logic [QW-1:0] qcnt_ff;
	logic [1:0] q_ff, byte_ff, last_byte;
	logic [3:0] bit_ff;
	logic [31:0] frame_ff;
	logic [15:0] rx_ff;
	logic rw_ff, scl_ff, oe_ff, nack_ff, sda_s, tick, rd_byte;

	aldbc_sync #(.P_WIDTH(1)) u_sda_sync (
		.i_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_d(link.sda),
		.o_q(sda_s)
	);

	assign tick = qcnt_ff == QW'(P_QTR - 1);
	assign rd_byte = rw_ff && (byte_ff != 2'h0);
	assign last_byte = rw_ff ? 2'(aldbc_pkg::DB_COUNT) : 2'(aldbc_pkg::IB_COUNT);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qcnt_ff <= '0;
		end else begin
			qcnt_ff <= (tick || st_ff == aldbc_pkg::H_IDLE) ? '0 : qcnt_ff + QW'(1);
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= aldbc_pkg::H_IDLE;
			{q_ff, byte_ff, bit_ff} <= 8'h00;
			frame_ff <= 32'h00000000;
			rx_ff <= 16'h0000;
			{rw_ff, nack_ff, oe_ff} <= 3'h0;
			scl_ff <= 1'b1;
			o_done <= 1'b0;
			o_nack <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_done <= 1'b0;
			case (st_ff)
				aldbc_pkg::H_IDLE: begin
					if (i_start) begin
						frame_ff <= {i_addr, i_rw, i_wdata};
						rw_ff <= i_rw;
						{q_ff, byte_ff, bit_ff, nack_ff} <= 9'h000;
						st_ff <= aldbc_pkg::H_START;
					end
				end
				aldbc_pkg::H_START: begin
					if (tick) begin
						q_ff <= q_ff + 2'h1;
						if (q_ff == 2'h1) begin
							oe_ff <= 1'b1;
						end else if (q_ff == 2'h3) begin
							scl_ff <= 1'b0;
							st_ff <= aldbc_pkg::H_BIT;
						end
					end
				end
				aldbc_pkg::H_BIT: begin
					if (tick) begin
						q_ff <= q_ff + 2'h1;
						case (q_ff)
							2'h0: begin
								if (bit_ff == 4'h8) begin
									oe_ff <= rd_byte && byte_ff != last_byte;
								end else begin
									oe_ff <= !rd_byte && !frame_ff[31];
								end
							end
							2'h1: scl_ff <= 1'b1;
							2'h2: begin
								if (bit_ff != 4'h8 && rd_byte) begin
									rx_ff <= {rx_ff[14:0], sda_s};
								end else if (bit_ff == 4'h8 && !rd_byte && sda_s) begin
									nack_ff <= 1'b1;
								end
							end
							default: begin
								scl_ff <= 1'b0;
								if (bit_ff != 4'h8) begin
									bit_ff <= bit_ff + 4'h1;
									frame_ff <= {frame_ff[30:0], 1'b0};
								end else if (nack_ff || byte_ff == last_byte) begin
									st_ff <= aldbc_pkg::H_STOP;
								end else begin
									bit_ff <= 4'h0;
									byte_ff <= byte_ff + 2'h1;
								end
							end
						endcase
					end
				end
				default: begin
					if (tick) begin
						q_ff <= q_ff + 2'h1;
						case (q_ff)
							2'h0: oe_ff <= 1'b1;
							2'h1: scl_ff <= 1'b1;
							2'h2: oe_ff <= 1'b0;
							default: begin
								st_ff <= aldbc_pkg::H_IDLE;
								o_done <= 1'b1;
								o_nack <= nack_ff;
								o_rdata <= rx_ff;
							end
						endcase
					end
				end
			endcase
		end
	end

	assign o_busy = st_ff != aldbc_pkg::H_IDLE;
	assign link.scl = scl_ff;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe = oe_ff;
endmodule : aldbc_host

// File: src/aldbc_link_if.sv
/*
 * Two-wire link between the host and the amplifier device.
 * Assumes SDA is open drain with a pull-up; the level is resolved here.
 */
`timescale 1ns/1ns
interface aldbc_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host(output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface : aldbc_link_if

// File: src/aldbc_pkg.sv
/*
 * Shared constants and types of the amplifier diagnostic and two-wire control block.
 * Assumes a 50 MHz system clock on both ends.
 */
package aldbc_pkg;
	// Instruction byte bit positions.
	localparam int IB_ON = 0;
	localparam int IB_CH_OFF = 1;
	localparam int IB_DET_EN = 2;
	localparam int IB_AC_EN = 4;
	localparam int IB_CLIP_OFF = 5;
	localparam int IB_PIN_LATCH = 7;
	// Status byte bit positions.
	localparam int DB1_NO_IB = 7;
	localparam int DB1_VALID = 6;
	localparam int DB1_OVP = 5;
	localparam int DB_OPEN = 4;
	localparam int DB_SHORT = 3;
	localparam int DB1_OFFSET = 2;
	localparam int DB2_OTP = 7;
	localparam int DB2_TPW = 6;
	localparam int DB2_UVP = 5;
	// Reset values.
	localparam logic [7:0] IB_RST = 8'h00;
	localparam logic [15:0] DB_RST = 16'h0000;
	// Resistor codes: 0 short, 1 to 5 for 4.7k, 13k, 33k, 100k and open.
	localparam logic [2:0] ADS_SHORT = 3'h0;
	localparam logic [2:0] MOD_PARALLEL = 3'h3;
	localparam logic [3:0] ADDR_HI_BASE = 4'h5;
	localparam logic [2:0] RES_CODE_RST = 3'h5;
	// Number of instruction bytes in a write and status bytes in a read.
	localparam int IB_COUNT = 3;
	localparam int DB_COUNT = 2;
	// Timing.
	localparam int SYS_KHZ = 50000;
	localparam int HOLD_MS = 50;
	localparam int HOLD_CYC = HOLD_MS * SYS_KHZ;
	localparam int SCL_QTR_CYC = 125;

	typedef enum logic [2:0] {PWR_OFF, PWR_RUN, PWR_MUTE, PWR_DISCH, PWR_HOLD} aldbc_pwr_t;
	typedef enum logic [1:0] {PH_ADDR, PH_WR, PH_RD, PH_IGN} aldbc_ph_t;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} aldbc_hst_t;
endpackage : aldbc_pkg

// File: src/aldbc_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level or a toggle; words are not kept coherent.
 */
`timescale 1ns/1ns
module aldbc_sync #(
	parameter int P_WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [P_WIDTH-1:0] i_d,
	output logic [P_WIDTH-1:0] o_q
);
	logic [P_WIDTH-1:0] meta_ff;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_ff <= '0;
			o_q <= '0;
		end else begin
			meta_ff <= i_d;
			o_q <= meta_ff;
		end
	end
endmodule : aldbc_sync

// File: verif/aldbc_link_monitor.sv
/*
 * Checker of the two-wire link between the host end and the device end.
 * Assumes the host quarter bit period is four system clocks.
 */
`timescale 1ns/1ns
module aldbc_link_monitor (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	logic scl_ff, sda_ff, rw_ff;
	logic [3:0] bit_ff;
	logic [1:0] nbyte_ff;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Previous link levels.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
		end else begin
			scl_ff <= scl;
			sda_ff <= sda;
		end
	end
	// Bit and byte position in a frame, and the direction bit.
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bit_ff <= 4'h0;
			nbyte_ff <= 2'h0;
			rw_ff <= 1'b0;
		end else if (scl && scl_ff && sda_ff && !sda) begin
			bit_ff <= 4'h0;
			nbyte_ff <= 2'h0;
		end else if (scl && !scl_ff) begin
			if (bit_ff == 4'h8) begin
				bit_ff <= 4'h0;
				if (nbyte_ff != 2'h3) begin
					nbyte_ff <= nbyte_ff + 2'h1;
				end
			end else begin
				bit_ff <= bit_ff + 4'h1;
			end
			if (nbyte_ff == 2'h0 && bit_ff == 4'h7) begin
				rw_ff <= sda;
			end
		end
	end
	a_dev_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed SDA while SCL high");
	a_start_form: assert property (scl && $fell(sda) |-> !dev_sda_oe ##[2:12] !scl)
		else $error("start condition malformed");
	a_stop_form: assert property (scl && $rose(sda) |-> !host_sda_oe && !dev_sda_oe ##1 scl [*4])
		else $error("stop condition malformed");
	a_bit_stable: assert property ($rose(scl) |-> $stable(sda) [*3])
		else $error("SDA moved around SCL rise");
	a_scl_low_bound: assert property ($fell(scl) |-> ##[2:16] $rose(scl))
		else $error("SCL low too long");
	a_dev_oe_stands: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
		else $error("device SDA drive too short");
	a_wr_dev_quiet: assert property (scl && scl_ff && !rw_ff && nbyte_ff != 2'h0 && bit_ff != 4'h0 |-> !dev_sda_oe)
		else $error("device drove SDA during write data");
	a_rd_ack_host: assert property (scl && scl_ff && rw_ff && nbyte_ff[1] && bit_ff == 4'h0 |-> !dev_sda_oe)
		else $error("device drove SDA in host acknowledge slot");
	c_start: cover property (scl && $fell(sda));
	c_dev_ack: cover property ($rose(dev_sda_oe));
	c_read: cover property (scl && scl_ff && rw_ff && nbyte_ff[1]);
endmodule : aldbc_link_monitor

// File: verif/amp_load_diag_bus_control_bench.sv
/*
 * Bench of the amplifier diagnostic block: host and device ends joined by the link.
 * Assumes the package is compiled first and short counts are set by parameters.
 */
`timescale 1ns/1ns
module amp_load_diag_bus_control_bench;
	logic i_sys_clk, i_rst_n, st, rw, done, busy, nack;
	logic [6:0] addr;
	logic [23:0] wdata;
	logic [15:0] rdata;
	logic det_done, low_supply_guard, hang, ac_over, osw, en, muted, empty, slave;
	logic [1:0] open, overcurrent_guard, clip, chen;
	logic [2:0] bus_addr_resistor_pin, mods;
	logic det_en, det_st, ac_en, clip_oe, mute, disch, off, osc, bmode;
	logic [7:0] waddr;
	int n_errors, n_compared, n_starts, s0;
	aldbc_link_if link_if();
	aldbc_host #(.P_QTR(4)) aldbc_host_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_start(st),
		.i_rw(rw), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nack(nack),
		.o_rdata(rdata), .link(link_if));
	aldbc_dev #(.P_HOLD_CYC(20)) aldbc_dev_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_det_done(det_done), .i_open(open), .i_ocp(overcurrent_guard), .i_uvp(low_supply_guard), .i_ovp(1'b0), .i_hang(hang),
		.i_offset(1'b0), .i_otp(1'b0), .i_tpw(1'b0), .i_clip(clip), .i_ac_over(ac_over),
		.i_ads_code(bus_addr_resistor_pin), .i_mod_code(mods), .i_out_switching(osw), .i_en_pin(en), .i_muted(muted),
		.i_soft_ramp_cap_pin_empty(empty), .i_slave_mode(slave), .o_det_enable(det_en), .o_det_start(det_st),
		.o_ch_enable(chen), .o_ac_det_enable(ac_en), .o_clip_o(), .o_clip_oe(clip_oe), .o_mute(mute),
		.o_soft_ramp_cap_pin_discharge(disch), .o_off(off), .o_osc_run(osc), .o_bus_mode(bmode),
		.o_wr_addr(waddr), .link(link_if));
	aldbc_link_monitor aldbc_link_monitor_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.scl(link_if.scl), .sda(link_if.sda), .host_sda_oe(link_if.host_sda_oe),
		.dev_sda_oe(link_if.dev_sda_oe));
	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) if (det_st === 1'b1) n_starts <= n_starts + 1;
	task automatic results();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : wt
	task automatic xfer(input logic r, input logic [6:0] a, input logic [23:0] d);
		int k;
		@(negedge i_sys_clk);
		st = 1'b1;
		rw = r;
		addr = a;
		wdata = d;
		@(negedge i_sys_clk);
		st = 1'b0;
		chk("busy", 16'h0001, busy);
		for (k = 0; k < 2000 && done !== 1'b1; k++) begin
			@(negedge i_sys_clk);
		end
		chk("done", 16'h0001, done);
		wt(6);
	endtask : xfer
	initial begin
		wt(40000);
		n_errors++;
		results();
	end
	initial begin
		{i_rst_n, st, rw, addr, wdata, hang, det_done, low_supply_guard, ac_over, osw, en, muted, empty, slave} = '0;
		{open, overcurrent_guard, clip} = '0;
		bus_addr_resistor_pin = 3'h5;
		mods = 3'h1;
		n_errors = 0;
		n_compared = 0;
		wt(10);
		i_rst_n = 1'b1;
		wt(10);
		chk("addr", 16'h0068, waddr);
		chk("bus", 16'h0001, bmode);
		chk("detect", 16'h0000, {det_en, ac_en});
		xfer(1'b0, 7'h35, 24'h000400);
		chk("nack", 16'h0002, {nack, det_en});
		xfer(1'b0, 7'h34, 24'h000400);
		chk("start", 16'h0003, {det_en, n_starts == 1});
		open = 2'h1;
		det_done = 1'b1;
		wt(6);
		xfer(1'b1, 7'h34, 24'h000000);
		chk("load", 16'h5000, rdata);
		overcurrent_guard = 2'h3;
		wt(6);
		overcurrent_guard = 2'h0;
		xfer(1'b1, 7'h34, 24'h000000);
		chk("short", 16'h5808, rdata);
		xfer(1'b1, 7'h34, 24'h000000);
		chk("cleared", 16'h5000, rdata);
		low_supply_guard = 1'b1;
		wt(6);
		low_supply_guard = 1'b0;
		xfer(1'b1, 7'h34, 24'h000000);
		chk("invalid", 16'h1020, rdata);
		det_done = 1'b0;
		xfer(1'b0, 7'h34, 24'h000000);
		s0 = n_starts;
		xfer(1'b0, 7'h34, 24'h000400);
		chk("restart", 16'h0001, 16'(n_starts - s0));
		for (int t = 0; t < 3 && rdata[14] !== 1'b1; t++) begin
			hang = (t == 0);
			det_done = 1'b1;
			wt(6);
			xfer(1'b1, 7'h34, 24'h000000);
			chk("retry valid", (t == 0) ? 16'h0000 : 16'h0001, rdata[14]);
			{hang, det_done} = 2'h0;
			xfer(1'b0, 7'h34, 24'h000000);
			xfer(1'b0, 7'h34, 24'h000400);
		end
		xfer(1'b0, 7'h34, 24'h010000);
		chk("channels", 16'h0003, chen);
		s0 = n_starts;
		xfer(1'b0, 7'h34, 24'h010400);
		chk("no restart", 16'h0000, 16'(n_starts - s0));
		clip = 2'h1;
		wt(6);
		chk("clip", 16'h0001, clip_oe);
		xfer(1'b0, 7'h34, 24'h210400);
		chk("clip off", 16'h0000, clip_oe);
		clip = 2'h0;
		ac_over = 1'b1;
		wt(6);
		chk("ac off", 16'h0000, clip_oe);
		xfer(1'b0, 7'h34, 24'h210410);
		chk("ac on", 16'h0003, {ac_en, clip_oe});
		ac_over = 1'b0;
		for (int s = 0; s < 2; s++) begin
			slave = s[0];
			muted = 1'b0;
			empty = 1'b0;
			en = 1'b1;
			wt(8);
			chk("run", 16'h0000, {off, mute});
			en = 1'b0;
			wt(8);
			chk("mute", 16'h0002, {mute, disch});
			muted = 1'b1;
			wt(8);
			chk("discharge", 16'h0001, disch);
			empty = 1'b1;
			wt(8);
			chk("hold", (s == 1) ? 16'h0002 : 16'h0001, {off, osc});
			wt(30);
			chk("off", 16'h0002, {off, osc});
		end
		bus_addr_resistor_pin = 3'h1;
		mods = 3'h3;
		wt(6);
		chk("held", 16'h0068, waddr);
		xfer(1'b0, 7'h34, 24'h010080);
		chk("latched", 16'h0050, waddr);
		xfer(1'b1, 7'h34, 24'h000000);
		chk("old addr", 16'h0001, nack);
		xfer(1'b1, 7'h28, 24'h000000);
		chk("new addr", 16'h0000, nack);
		xfer(1'b0, 7'h28, 24'h010000);
		bus_addr_resistor_pin = 3'h5;
		mods = 3'h1;
		osw = 1'b1;
		wt(6);
		chk("switching", 16'h0068, waddr);
		osw = 1'b0;
		results();
	end
endmodule : amp_load_diag_bus_control_bench
